// File: rtl/bridge_excitation_defs.vh
// constants for the bridge excitation drive block
`ifndef BRIDGE_EXCITATION_DEFS_VH
`define BRIDGE_EXCITATION_DEFS_VH

// register byte addresses
`define REG_CONTROL_ADDR        8'h00
`define REG_HALF_PERIOD_ADDR    8'h04
`define REG_STATUS_ADDR         8'h08
`define REG_REVERSAL_COUNT_ADDR 8'h0C

// control register fields
`define CTRL_FUNCTION_SELECT_BIT 0
`define CTRL_LOWER_BIT           1
`define CTRL_UPPER_BIT           2
`define CTRL_AC_ENABLE_BIT       3
`define CTRL_CHOP_ENABLE_BIT     4
`define CTRL_WIDTH               5
`define CTRL_RESET_VALUE         5'h00

// status register fields
`define STAT_PHASE_BIT    0
`define STAT_INVERTED_BIT 1
`define STAT_ACTIVE_BIT   2
`define STAT_STATE_LSB    3
`define STAT_STATE_MSB    4

// one less than the half period of the excitation phase, in master clock cycles
`define HALF_PERIOD_WIDTH       16
`define HALF_PERIOD_RESET_VALUE 16'h0100

// phase sequencer states
`define PHASE_NORMAL     2'b00
`define PHASE_GAP_TO_REV 2'b01
`define PHASE_REVERSED   2'b10
`define PHASE_GAP_TO_NRM 2'b11

`endif

// File: rtl/excitation_phase_gen.v
// non-overlapping excitation phase sequencer
`include "bridge_excitation_defs.vh"

module excitation_phase_gen
(
	input  wire       mclk,
	input  wire       arst_n,
	input  wire       active,
	input  wire       toggle_tick,
	output reg        excitation_phase_out,
	output reg        excitation_phase_inverted_out,
	output reg  [1:0] phase_state,
	output reg        reversal_done
);

	localparam NORMAL     = `PHASE_NORMAL;
	localparam GAP_TO_REV = `PHASE_GAP_TO_REV;
	localparam REVERSED   = `PHASE_REVERSED;
	localparam GAP_TO_NRM = `PHASE_GAP_TO_NRM;

	reg [1:0] next_phase_state;

	always @*
	begin
		next_phase_state = phase_state;
		case (phase_state)
			NORMAL:
				if (active && toggle_tick)
					next_phase_state = GAP_TO_REV;
			GAP_TO_REV:
				// a gap always lasts one cycle, even if disabled meanwhile
				next_phase_state = active ? REVERSED : NORMAL;
			REVERSED:
				// leaving reversal also goes through the gap
				if (!active || toggle_tick)
					next_phase_state = GAP_TO_NRM;
			GAP_TO_NRM:
				next_phase_state = NORMAL;
			default:
				next_phase_state = NORMAL;
		endcase
	end

	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			phase_state                   <= NORMAL;
			excitation_phase_out          <= 1'b1;
			excitation_phase_inverted_out <= 1'b0;
			reversal_done                 <= 1'b0;
		end
		else
		begin
			phase_state <= next_phase_state;
			// phase outputs decoded from the next state and registered; reversal_done from the current state
			excitation_phase_out <= (next_phase_state == NORMAL);
			excitation_phase_inverted_out <=
				(next_phase_state == REVERSED);
			reversal_done <= (phase_state == GAP_TO_REV) ||
				(phase_state == GAP_TO_NRM);
		end
	end

endmodule // excitation_phase_gen

// File: rtl/bridge_excitation_drive.v
// bridge excitation drive: register port, shared pins, phase timing
`include "bridge_excitation_defs.vh"

// Contract
// - a control bit chooses analog input or digital outputs on shared pins
// - in digital mode the positive shared pin follows the upper output bit
// - in digital mode the negative shared pin follows the lower output bit
// - phase output high means normal excitation, low means reversed
// - phase output stays high unless both excitation enables are set
// - inverted phase output is the complement, toggling in anti-phase
// - inverted phase output stays low unless both enables are set
// - both phase outputs low for exactly one cycle at each toggle
module bridge_excitation_drive
#(
	parameter ADDR_WIDTH = 8,
	parameter DATA_WIDTH = 32,
	parameter HP_WIDTH   = `HALF_PERIOD_WIDTH,
	parameter CNT_WIDTH  = 16
)
(
	input  wire                  mclk,
	input  wire                  arst_n,
	input  wire [ADDR_WIDTH-1:0] reg_addr,
	input  wire [DATA_WIDTH-1:0] reg_wdata,
	input  wire                  reg_write,
	input  wire                  reg_read,
	output reg  [DATA_WIDTH-1:0] reg_rdata,
	output wire                  excitation_phase_out,
	output wire                  excitation_phase_inverted_out,
	output reg                   shared_positive_pin_out,
	output reg                   shared_positive_pin_oe_n,
	output reg                   shared_negative_pin_out,
	output reg                   shared_negative_pin_oe_n,
	output reg                   analog_pair_select
);

	// control register
	reg  [`CTRL_WIDTH-1:0] control;
	wire                   shared_pin_function_select;
	wire                   general_output_lower_bit;
	wire                   general_output_upper_bit;
	wire                   alternating_excitation_enable;
	wire                   chopping_enable;

	// timing
	reg  [HP_WIDTH-1:0]    half_period;
	reg  [HP_WIDTH-1:0]    divider;
	reg  [HP_WIDTH-1:0]    next_divider;
	reg                    toggle_tick;
	wire                   active;

	// status
	wire [1:0]             phase_state;
	wire                   reversal_done;
	reg  [CNT_WIDTH-1:0]   reversal_count;

	// bus decode
	wire                   hit_control;
	wire                   hit_half_period;
	wire                   hit_status;
	wire                   hit_count;
	reg  [DATA_WIDTH-1:0]  next_rdata;

	// a programmed half period of zero behaves as one
	function [HP_WIDTH-1:0] effective_half;
		input [HP_WIDTH-1:0] value;
		begin
			if (value == {HP_WIDTH{1'b0}})
				effective_half = {{(HP_WIDTH-1){1'b0}}, 1'b1};
			else
				effective_half = value;
		end
	endfunction

	function addr_match;
		input [ADDR_WIDTH-1:0] addr;
		input [7:0]            target;
		begin
			addr_match = (addr == target[ADDR_WIDTH-1:0]);
		end
	endfunction

	assign shared_pin_function_select =
		control[`CTRL_FUNCTION_SELECT_BIT];
	assign general_output_lower_bit = control[`CTRL_LOWER_BIT];
	assign general_output_upper_bit = control[`CTRL_UPPER_BIT];
	assign alternating_excitation_enable =
		control[`CTRL_AC_ENABLE_BIT];
	assign chopping_enable = control[`CTRL_CHOP_ENABLE_BIT];

	// toggling only when both enables are set
	assign active = alternating_excitation_enable &&
		chopping_enable;

	assign hit_control     = addr_match(reg_addr, `REG_CONTROL_ADDR);
	assign hit_half_period = addr_match(reg_addr, `REG_HALF_PERIOD_ADDR);
	assign hit_status      = addr_match(reg_addr, `REG_STATUS_ADDR);
	assign hit_count       = addr_match(reg_addr, `REG_REVERSAL_COUNT_ADDR);

	// register writes
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			control     <= `CTRL_RESET_VALUE;
			half_period <= `HALF_PERIOD_RESET_VALUE;
		end
		else if (reg_write)
		begin
			if (hit_control)
				control <= reg_wdata[`CTRL_WIDTH-1:0];
			if (hit_half_period)
				half_period <= reg_wdata[HP_WIDTH-1:0];
		end
	end

	// read data stands only in the cycle after the read strobe
	always @*
	begin
		next_rdata = {DATA_WIDTH{1'b0}};
		if (reg_read)
		begin
			if (hit_control)
				next_rdata[`CTRL_WIDTH-1:0] = control;
			else if (hit_half_period)
				next_rdata[HP_WIDTH-1:0] = half_period;
			else if (hit_status)
			begin
				next_rdata[`STAT_PHASE_BIT] = excitation_phase_out;
				next_rdata[`STAT_INVERTED_BIT] =
					excitation_phase_inverted_out;
				next_rdata[`STAT_ACTIVE_BIT] = active;
				next_rdata[`STAT_STATE_MSB:`STAT_STATE_LSB] = phase_state;
			end
			else if (hit_count)
				next_rdata[CNT_WIDTH-1:0] = reversal_count;
		end
	end

	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= {DATA_WIDTH{1'b0}};
		else
			reg_rdata <= next_rdata;
	end

	// half-period divider; held cleared while idle so a new start
	// always gives a full first half period
	always @*
	begin
		next_divider = divider + {{(HP_WIDTH-1){1'b0}}, 1'b1};
		if (!active || toggle_tick)
			next_divider = {HP_WIDTH{1'b0}};
		else if (divider >= effective_half(half_period) -
			{{(HP_WIDTH-1){1'b0}}, 1'b1})
			next_divider = {HP_WIDTH{1'b0}};
	end

	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			divider     <= {HP_WIDTH{1'b0}};
			toggle_tick <= 1'b0;
		end
		else
		begin
			divider     <= next_divider;
			toggle_tick <= active && !toggle_tick &&
				(divider >= effective_half(half_period) -
				{{(HP_WIDTH-1){1'b0}}, 1'b1});
		end
	end

	excitation_phase_gen excitation_phase_gen_i
	(
		.mclk                          (mclk),
		.arst_n                        (arst_n),
		.active                        (active),
		.toggle_tick                   (toggle_tick),
		.excitation_phase_out          (excitation_phase_out),
		.excitation_phase_inverted_out (excitation_phase_inverted_out),
		.phase_state                   (phase_state),
		.reversal_done                 (reversal_done)
	);

	// passes through either gap state, aborted ones included, wraps; read-only
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			reversal_count <= {CNT_WIDTH{1'b0}};
		else if (reversal_done)
			reversal_count <= reversal_count +
				{{(CNT_WIDTH-1){1'b0}}, 1'b1};
	end

	// shared pins: driven only in digital mode, else released to analog
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			shared_positive_pin_out  <= 1'b0;
			shared_positive_pin_oe_n <= 1'b1;
			shared_negative_pin_out  <= 1'b0;
			shared_negative_pin_oe_n <= 1'b1;
			analog_pair_select       <= 1'b1;
		end
		else
		begin
			shared_positive_pin_oe_n <= !shared_pin_function_select;
			shared_negative_pin_oe_n <= !shared_pin_function_select;
			analog_pair_select       <= !shared_pin_function_select;
			shared_positive_pin_out  <= shared_pin_function_select &&
				general_output_upper_bit;
			shared_negative_pin_out  <= shared_pin_function_select &&
				general_output_lower_bit;
		end
	end

endmodule // bridge_excitation_drive

// File: bench/bridge_excitation_drive_asserts.sv
// port checker for the bridge excitation drive
module bridge_excitation_drive_asserts
#(
	parameter ADDR_WIDTH = 8,
	parameter DATA_WIDTH = 32
)
(
	input wire logic                  mclk,
	input wire logic                  arst_n,
	input wire logic [ADDR_WIDTH-1:0] reg_addr,
	input wire logic [DATA_WIDTH-1:0] reg_wdata,
	input wire logic                  reg_write,
	input wire logic                  excitation_phase_out,
	input wire logic                  excitation_phase_inverted_out,
	input wire logic                  shared_positive_pin_out,
	input wire logic                  shared_positive_pin_oe_n,
	input wire logic                  shared_negative_pin_out,
	input wire logic                  analog_pair_select
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] ctl;
	wire        act = ctl[3] & ctl[4];
	wire        ph  = excitation_phase_out;
	wire        inv = excitation_phase_inverted_out;
	// shadow of the control word, updated on the same edge as the design
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
			ctl <= 5'h00;
		else if (reg_write && reg_addr == 8'h00)
			ctl <= reg_wdata[4:0];
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	property p_sel;
		analog_pair_select != $past(ctl[0])
			&& shared_positive_pin_oe_n != $past(ctl[0]);
	endproperty
	a_sel: assert property (p_sel) else $error("pin mode wrong");
	property p_up;
		$past(ctl[0]) |-> shared_positive_pin_out == $past(ctl[2]);
	endproperty
	a_up: assert property (p_up) else $error("upper pin wrong");
	property p_lo;
		$past(ctl[0]) |-> shared_negative_pin_out == $past(ctl[1]);
	endproperty
	a_lo: assert property (p_lo) else $error("lower pin wrong");
	property p_idle; (!act)[*4] |-> ph && !inv; endproperty
	a_idle: assert property (p_idle) else $error("idle level");
	property p_apart; !(ph && inv); endproperty
	a_apart: assert property (p_apart) else $error("overlap");
	property p_fph; $fell(ph) |-> !inv; endproperty
	a_fph: assert property (p_fph) else $error("no gap at fall");
	property p_finv; $fell(inv) |-> !ph ##1 ph; endproperty
	a_finv: assert property (p_finv) else $error("bad return");
	property p_gap1; !ph && !inv |=> ph || inv; endproperty
	a_gap1: assert property (p_gap1) else $error("gap too long");
	c_rev: cover property ($rose(inv));
	c_dig: cover property (!shared_positive_pin_oe_n
		&& shared_positive_pin_out);
	c_back: cover property ($rose(ph) && !act);
endmodule // bridge_excitation_drive_asserts

bind bridge_excitation_drive bridge_excitation_drive_asserts
	#(.ADDR_WIDTH(ADDR_WIDTH), .DATA_WIDTH(DATA_WIDTH))
	bridge_excitation_drive_asserts_i (.*);

// File: bench/excitation_switch_model.sv
// far side model: bridge reversal switches steered by the phase lines
module excitation_switch_model
(
	input wire logic mclk,
	input wire logic phase,
	input wire logic phase_inv,
	output logic     reversed = 1'b0,
	output int       overlaps = 0
);
	timeunit 1ns;
	timeprecision 1ps;
	// a gap keeps the last switch state, so the bridge never floats
	always @(posedge mclk)
	begin
		if (phase && phase_inv)
			overlaps <= overlaps + 1;
		else if (phase_inv)
			reversed <= 1'b1;
		else if (phase)
			reversed <= 1'b0;
	end
endmodule // excitation_switch_model

// File: bench/bridge_excitation_drive_tb_top.sv
// testbench for the bridge excitation drive
module bridge_excitation_drive_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 1'b0;
	logic        arst_n = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic        reg_write = 1'b0;
	logic        reg_read = 1'b0;
	logic [31:0] reg_rdata;
	logic        ph, inv, pp, pp_oe_n, np, np_oe_n, ana, rev;
	int          overlaps;
	int          err_count = 0;
	int          n_checks = 0;
	always #2 mclk = ~mclk;
	bridge_excitation_drive bridge_excitation_drive_i (
		.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .excitation_phase_out(ph),
		.excitation_phase_inverted_out(inv),
		.shared_positive_pin_out(pp), .shared_positive_pin_oe_n(pp_oe_n),
		.shared_negative_pin_out(np), .shared_negative_pin_oe_n(np_oe_n),
		.analog_pair_select(ana));
	excitation_switch_model excitation_switch_model_i (.mclk(mclk),
		.phase(ph), .phase_inv(inv), .reversed(rev), .overlaps(overlaps));
	task automatic chk(input string what, input logic [31:0] exp, got);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge mclk);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge mclk);
		reg_read <= 1'b0;
		@(negedge mclk);
		chk("rdata", exp, reg_rdata);
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	function automatic logic [31:0] pins();
		return {27'h0, ana, pp_oe_n, np_oe_n, pp, np};
	endfunction
	function automatic logic [31:0] phases();
		return {30'h0, ph, inv};
	endfunction
	// stops at the first cycle the chosen line is seen low
	task automatic seek_low(input bit on_inv);
		for (int n = 0; n < 40; n++)
		begin
			@(negedge mclk);
			if ((on_inv ? inv : ph) === 1'b0)
				return;
		end
		chk("toggle", 32'h0000_0001, 32'h0000_0000);
	endtask
	task automatic t_reset;
		wait_cyc(1);
		chk("rst_pins", 32'h0000_001C, pins());
		chk("rst_phase", 32'h0000_0002, phases());
		rd(8'h04, 32'h0000_0100);
		rd(8'h10, 32'h0000_0000);
		$display("test reset done");
	endtask
	task automatic t_pins;
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h00, 32'(1 + 2 * i));
			wait_cyc(2);
			chk("dig_pins", {30'h0, i[1:0]}, pins());
		end
		wr(8'h00, 32'h0000_0006);
		wait_cyc(2);
		chk("ana_pins", 32'h0000_001C, pins());
		$display("test pins done");
	endtask
	task automatic t_phase;
		wr(8'h04, 32'h0000_0002);
		wr(8'h00, 32'h0000_0018);
		rd(8'h08, 32'h0000_0005);
		seek_low(1'b0);
		chk("gap_rev", 32'h0000_0000, phases());
		wait_cyc(1);
		chk("reversed", 32'h0000_0001, phases());
		wait_cyc(1);
		chk("far_rev", 32'h0000_0001, {31'h0, rev});
		seek_low(1'b1);
		chk("gap_nrm", 32'h0000_0000, phases());
		wait_cyc(1);
		chk("normal", 32'h0000_0002, phases());
		wait_cyc(1);
		chk("far_nrm", 32'h0000_0000, {31'h0, rev});
		$display("test phase done");
	endtask
	task automatic t_disable;
		seek_low(1'b0);
		wr(8'h00, 32'h0000_0008);
		wait_cyc(4);
		chk("ac_only", 32'h0000_0002, phases());
		rd(8'h08, 32'h0000_0001);
		wr(8'h00, 32'h0000_0010);
		wait_cyc(8);
		chk("chop_only", 32'h0000_0002, phases());
		chk("overlaps", 32'h0000_0000, 32'(overlaps));
		rd(8'h0C, 32'h0000_0004);
		rd(8'h00, 32'h0000_0010);
		rd(8'h04, 32'h0000_0002);
		$display("test disable done");
	endtask
	initial
	begin
		repeat (10) @(posedge mclk);
		arst_n <= 1'b1;
		t_reset();
		t_pins();
		t_phase();
		t_disable();
		tally_and_finish();
	end
	initial
	begin
		#5000;
		err_count++;
		tally_and_finish();
	end
endmodule // bridge_excitation_drive_tb_top
